// File: include/ddi_pkg.sv
/*
 * shared constants of the dual dac input interface: register map, field positions,
 * reset values, widths and timing figures.
 * assumes a 25 MHz system clock and classic wishbone software access.
 */
`default_nettype none

package ddi_pkg;

    // ------------------------------------------------------------
    // widths and converter figures
    // ------------------------------------------------------------
    localparam int DDI_CODE_W = 14;
    localparam logic [13:0] DDI_CODE_MAX = 14'h3fff;
    localparam int DDI_FULL_SCALE = 16384;
    localparam int DDI_LAT_CYCLES = 4;
    localparam int DDI_SEG_BITS = 5;
    localparam int DDI_SEG_N = 31;
    localparam int DDI_MAX_UPDATE_MSPS = 275;
    localparam int DDI_CLK_MHZ = 25;
    localparam int DDI_CLK_PERIOD_NS = 1000 / DDI_CLK_MHZ;
    localparam int DDI_CLK_WRITE_SEP_NS = 2;
    localparam int DDI_CLK_WRITE_SEP_CYC =
        (DDI_CLK_WRITE_SEP_NS + DDI_CLK_PERIOD_NS - 1) / DDI_CLK_PERIOD_NS;
    localparam int DDI_BUF_DEPTH = 2;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DDI_CTRL_OFS = 8'h00;
    localparam logic [7:0] DDI_STATUS_OFS = 8'h04;
    localparam logic [7:0] DDI_CODE_A_OFS = 8'h08;
    localparam logic [7:0] DDI_CODE_B_OFS = 8'h0c;

    // control fields
    localparam int DDI_CTRL_EN_A_BIT = 0;
    localparam int DDI_CTRL_EN_B_BIT = 1;
    localparam logic [1:0] DDI_CTRL_RST = 2'h3;

    // status fields
    localparam int DDI_ST_MODE_BIT = 0;
    localparam int DDI_ST_GAIN_BIT = 1;
    localparam int DDI_ST_DIV_BIT = 2;
    localparam int DDI_ST_STALL_BIT = 3;

    // strap meaning
    localparam logic DDI_MODE_INTERLEAVED = 1'b0;
    localparam logic DDI_MODE_DUAL = 1'b1;

endpackage : ddi_pkg

`default_nettype wire

// File: design/ddi_pair_buffer.sv
/*
 * two-entry valid/ready buffer for the converter sample stream.
 * assumes a single clock and a synchronous active-high reset.
 */
`default_nettype none

module ddi_pair_buffer #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;

    wire push = in_valid_i && (count_reg != FULL_CNT);
    wire pop = (count_reg != '0) && out_ready_i;

    assign in_ready_o = (count_reg != FULL_CNT);
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + PW'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + CW'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - CW'(1);
            end
        end
    end

endmodule : ddi_pair_buffer

`default_nettype wire

// File: design/ddi_top.sv
/*
 * digital input front end of a dual 14-bit current-steering converter: input
 * latches, dac latches, interleave steering, divide-by-two update clock,
 * segment decoder, sample stream buffer and a wishbone register slave.
 * assumes all pins are synchronous to clk_i and change slower than the clock;
 * in interleaved mode the channel a strobe and clock pins act as the shared ones.
 */
`default_nettype none

// Contract
// - a written word reaches the outputs exactly four update clocks later.
// - codes are straight positive binary, bit 13 is the msb.
// - update path is specified for rates up to 275 msps.
// - mode strap low selects interleaved, high selects dual independent buses.
// - dual mode: own bus, own write to input latch, own clock.
// - dual mode: channel word captured on rising edge of its write strobe.
// - interleaved mode uses only bus a; bus b is ignored.
// - interleaved: select high loads latch a, low loads latch b.
// - the unselected input latch holds its own value.
// - interleaved: capture on write rise, pass pair on write fall.
// - interleaved: shared clock divided by two forms dac latch clock.
// - divided clock low during align reset; release fixes pairing phase.
// - gain strap high shares bias resistor a, low uses separate resistors.
// - each update re-drives the segment switches from the new code.
// - primary current follows code, complementary follows 16383 minus code.
module ddi_top
    import ddi_pkg::*;
#(
    parameter int CODE_W = DDI_CODE_W,
    parameter int LAT = DDI_LAT_CYCLES,
    parameter int BUF_DEPTH = DDI_BUF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus_mode_strap_i,
    input wire logic gain_set_strap_i,
    input wire logic [CODE_W-1:0] bus_a_i,
    input wire logic [CODE_W-1:0] bus_b_i,
    input wire logic write_strobe_a_i,
    input wire logic write_strobe_b_i,
    input wire logic dac_clock_a_i,
    input wire logic dac_clock_b_i,
    input wire logic channel_select_i,
    input wire logic pair_align_reset_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [CODE_W-1:0] primary_current_a_o,
    output logic [CODE_W-1:0] complementary_current_a_o,
    output logic [CODE_W-1:0] primary_current_b_o,
    output logic [CODE_W-1:0] complementary_current_b_o,
    output logic [DDI_SEG_N-1:0] segment_switch_a_o,
    output logic [DDI_SEG_N-1:0] segment_switch_b_o,
    output logic divided_dac_latch_clock_o,
    output logic bias_b_from_resistor_a_o,
    output logic sample_valid_o,
    input wire logic sample_ready_i,
    output logic [CODE_W-1:0] sample_code_a_o,
    output logic [CODE_W-1:0] sample_code_b_o,
    output logic [1:0] sample_tag_o
);

    localparam int LOW_W = CODE_W - DDI_SEG_BITS;
    localparam int BUF_W = 2 * CODE_W + 2;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // complementary output code, full scale minus one minus code
    function automatic logic [CODE_W-1:0] comp_code(input logic [CODE_W-1:0] code);
        comp_code = DDI_CODE_MAX - code;
    endfunction : comp_code

    // msb segment to thermometer; lsbs stay binary-weighted in the code bus
    function automatic logic [DDI_SEG_N-1:0] therm(input logic [CODE_W-1:0] code);
        logic [DDI_SEG_BITS-1:0] msb;
        msb = code[CODE_W-1 -: DDI_SEG_BITS];
        for (int i = 0; i < DDI_SEG_N; i++) begin
            therm[i] = (msb > DDI_SEG_BITS'(i));
        end
    endfunction : therm

    // ------------------------------------------------------------
    // straps, caught once after reset release
    // ------------------------------------------------------------
    logic strap_done_reg;
    logic mode_reg;
    logic gain_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_done_reg <= 1'b0;
            mode_reg <= DDI_MODE_DUAL;
            gain_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            mode_reg <= bus_mode_strap_i;
            gain_reg <= gain_set_strap_i;
        end
    end

    wire dual_mode = (mode_reg == DDI_MODE_DUAL);
    wire run = strap_done_reg;

    // ------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------
    logic wr_a_prev_reg;
    logic wr_b_prev_reg;
    logic clk_a_prev_reg;
    logic clk_b_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_a_prev_reg <= 1'b0;
            wr_b_prev_reg <= 1'b0;
            clk_a_prev_reg <= 1'b0;
            clk_b_prev_reg <= 1'b0;
        end else begin
            wr_a_prev_reg <= write_strobe_a_i;
            wr_b_prev_reg <= write_strobe_b_i;
            clk_a_prev_reg <= dac_clock_a_i;
            clk_b_prev_reg <= dac_clock_b_i;
        end
    end

    // shared write strobe and shared update clock ride on the a pins
    wire wr_a_rise = run && write_strobe_a_i && !wr_a_prev_reg;
    wire wr_a_fall = run && !write_strobe_a_i && wr_a_prev_reg;
    wire wr_b_rise = run && write_strobe_b_i && !wr_b_prev_reg;
    wire clk_a_rise = run && dac_clock_a_i && !clk_a_prev_reg;
    wire clk_b_rise = run && dac_clock_b_i && !clk_b_prev_reg;

    // ------------------------------------------------------------
    // control and status registers
    // ------------------------------------------------------------
    logic [1:0] ctrl_reg;
    logic stall_reg;
    logic buf_ready;

    // ------------------------------------------------------------
    // input latches
    // ------------------------------------------------------------
    logic [CODE_W-1:0] in_latch_a_reg;
    logic [CODE_W-1:0] in_latch_b_reg;
    logic [CODE_W-1:0] pair_a_reg;
    logic [CODE_W-1:0] pair_b_reg;

    // bus b never feeds the latches in interleaved mode
    wire load_a = dual_mode ? wr_a_rise : (wr_a_rise && channel_select_i);
    wire load_b = dual_mode ? wr_b_rise : (wr_a_rise && !channel_select_i);
    wire [CODE_W-1:0] src_b = dual_mode ? bus_b_i : bus_a_i;
    wire [CODE_W-1:0] in_a_next = load_a ? bus_a_i : in_latch_a_reg;
    wire [CODE_W-1:0] in_b_next = load_b ? src_b : in_latch_b_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_latch_a_reg <= '0;
            in_latch_b_reg <= '0;
        end else begin
            in_latch_a_reg <= in_a_next;
            in_latch_b_reg <= in_b_next;
        end
    end

    // pair handed to the dac latches on the falling shared write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pair_a_reg <= '0;
            pair_b_reg <= '0;
        end else if (!dual_mode && wr_a_fall) begin
            pair_a_reg <= in_latch_a_reg;
            pair_b_reg <= in_latch_b_reg;
        end
    end

    // ------------------------------------------------------------
    // divided dac latch clock
    // ------------------------------------------------------------
    logic div_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 1'b0;
        end else if (pair_align_reset_i || dual_mode) begin
            div_reg <= 1'b0;
        end else if (clk_a_rise) begin
            div_reg <= !div_reg;
        end
    end

    // first shared clock rise after align release always gives a dac edge
    wire div_rise = !dual_mode && !pair_align_reset_i && clk_a_rise && !div_reg;

    // ------------------------------------------------------------
    // update events, gated by enable and by buffer room
    // ------------------------------------------------------------
    wire want_a = (dual_mode ? clk_a_rise : div_rise) && ctrl_reg[DDI_CTRL_EN_A_BIT];
    wire want_b = (dual_mode ? clk_b_rise : div_rise) && ctrl_reg[DDI_CTRL_EN_B_BIT];
    // a full buffer stalls the latch chain rather than dropping a sample
    wire upd_a = want_a && buf_ready;
    wire upd_b = want_b && buf_ready;
    wire stall_evt = (want_a || want_b) && !buf_ready;

    wire [CODE_W-1:0] dac_in_a = dual_mode ? in_latch_a_reg : pair_a_reg;
    wire [CODE_W-1:0] dac_in_b = dual_mode ? in_latch_b_reg : pair_b_reg;

    // ------------------------------------------------------------
    // dac latch chain: stage 0 is the dac latch, stage LAT-2 feeds the outputs
    // ------------------------------------------------------------
    logic [CODE_W-1:0] pipe_a_reg [0:LAT-1];
    logic [CODE_W-1:0] pipe_b_reg [0:LAT-1];

    wire [CODE_W-1:0] out_a_next = (LAT > 1) ? pipe_a_reg[LAT-2] : dac_in_a;
    wire [CODE_W-1:0] out_b_next = (LAT > 1) ? pipe_b_reg[LAT-2] : dac_in_b;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < LAT; i++) begin
                pipe_a_reg[i] <= '0;
                pipe_b_reg[i] <= '0;
            end
        end else begin
            if (upd_a) begin
                pipe_a_reg[0] <= dac_in_a;
                for (int i = 1; i < LAT; i++) begin
                    pipe_a_reg[i] <= pipe_a_reg[i-1];
                end
            end
            if (upd_b) begin
                pipe_b_reg[0] <= dac_in_b;
                for (int i = 1; i < LAT; i++) begin
                    pipe_b_reg[i] <= pipe_b_reg[i-1];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output codes and segment decoder
    // ------------------------------------------------------------
    // codes pass unchanged: straight binary, no sign handling
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primary_current_a_o <= '0;
            complementary_current_a_o <= DDI_CODE_MAX;
            segment_switch_a_o <= '0;
        end else if (upd_a) begin
            primary_current_a_o <= out_a_next;
            complementary_current_a_o <= comp_code(out_a_next);
            segment_switch_a_o <= therm(out_a_next);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primary_current_b_o <= '0;
            complementary_current_b_o <= DDI_CODE_MAX;
            segment_switch_b_o <= '0;
        end else if (upd_b) begin
            primary_current_b_o <= out_b_next;
            complementary_current_b_o <= comp_code(out_b_next);
            segment_switch_b_o <= therm(out_b_next);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divided_dac_latch_clock_o <= 1'b0;
            bias_b_from_resistor_a_o <= 1'b0;
        end else begin
            divided_dac_latch_clock_o <= div_reg;
            bias_b_from_resistor_a_o <= gain_reg;
        end
    end

    // ------------------------------------------------------------
    // sample stream buffer
    // ------------------------------------------------------------
    wire [BUF_W-1:0] buf_in = {upd_b, upd_a, out_b_next, out_a_next};
    wire [BUF_W-1:0] buf_out;

    ddi_pair_buffer #(
        .WIDTH(BUF_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(upd_a || upd_b),
        .in_ready_o(buf_ready),
        .in_data_i(buf_in),
        .out_valid_o(sample_valid_o),
        .out_ready_i(sample_ready_i),
        .out_data_o(buf_out)
    );

    assign sample_code_a_o = buf_out[CODE_W-1:0];
    assign sample_code_b_o = buf_out[2*CODE_W-1:CODE_W];
    assign sample_tag_o = buf_out[BUF_W-1 -: 2];

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_req = req && wb_we_i && wb_sel_i[0];
    wire hit_ctrl = (wb_adr_i == DDI_CTRL_OFS);
    wire hit_status = (wb_adr_i == DDI_STATUS_OFS);
    wire hit_code_a = (wb_adr_i == DDI_CODE_A_OFS);
    wire hit_code_b = (wb_adr_i == DDI_CODE_B_OFS);
    // write one clears the stall flag; a new stall in the same cycle wins
    wire stall_clr = wr_req && hit_status && wb_dat_i[DDI_ST_STALL_BIT];

    wire [31:0] status_word = {28'h0000_000, stall_reg, div_reg, gain_reg, mode_reg};
    wire [31:0] rd_word =
        hit_ctrl ? {30'h0000_0000, ctrl_reg} :
        hit_status ? status_word :
        hit_code_a ? {18'h0_0000, primary_current_a_o} :
        hit_code_b ? {18'h0_0000, primary_current_b_o} :
        32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= DDI_CTRL_RST;
        end else if (wr_req && hit_ctrl) begin
            ctrl_reg <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stall_reg <= 1'b0;
        end else if (stall_evt) begin
            stall_reg <= 1'b1;
        end else if (stall_clr) begin
            stall_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd_word : 32'h0000_0000;
        end
    end

endmodule : ddi_top

`default_nettype wire

// File: dv/ddi_top_sva.sv
/*
 * checker of ddi_top port relations.
 * assumes it is bound to ddi_top and sees only its ports.
 */
`default_nettype none

module ddi_top_sva
    import ddi_pkg::*;
#(
    parameter int CODE_W = DDI_CODE_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus_mode_strap_i,
    input wire logic gain_set_strap_i,
    input wire logic pair_align_reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [CODE_W-1:0] primary_current_a_o,
    input wire logic [CODE_W-1:0] complementary_current_a_o,
    input wire logic [CODE_W-1:0] primary_current_b_o,
    input wire logic [CODE_W-1:0] complementary_current_b_o,
    input wire logic [DDI_SEG_N-1:0] segment_switch_a_o,
    input wire logic divided_dac_latch_clock_o,
    input wire logic bias_b_from_resistor_a_o,
    input wire logic sample_valid_o,
    input wire logic sample_ready_i,
    input wire logic [CODE_W-1:0] sample_code_a_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // converter outputs
    // ----------------------------------------
    comp_a_sum_a: assert property (complementary_current_a_o == DDI_CODE_MAX - primary_current_a_o)
        else $error("complementary a not the inverse of primary a");
    comp_b_sum_a: assert property (complementary_current_b_o == DDI_CODE_MAX - primary_current_b_o)
        else $error("complementary b not the inverse of primary b");
    seg_therm_a: assert property (segment_switch_a_o == DDI_SEG_N'(
        (32'h0000_0001 << primary_current_a_o[CODE_W-1 -: DDI_SEG_BITS]) - 32'h0000_0001))
        else $error("segment switches do not match code");
    align_hold_a: assert property ((!bus_mode_strap_i && pair_align_reset_i) [*2]
        |=> !divided_dac_latch_clock_o)
        else $error("divided clock not held low in align reset");
    // strap caught after reset: skip two edges
    gain_strap_a: assert property (!$past(rst_i) && !$past(rst_i, 2)
        |-> bias_b_from_resistor_a_o == gain_set_strap_i)
        else $error("bias sharing does not follow gain strap");

    // ----------------------------------------
    // register bus and stream
    // ----------------------------------------
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    buf_hold_a: assert property (sample_valid_o && !sample_ready_i
        |=> sample_valid_o && $stable(sample_code_a_o))
        else $error("stalled sample lost or changed");
endmodule : ddi_top_sva

bind ddi_top ddi_top_sva #(.CODE_W(CODE_W)) u_sva (.*);

`default_nettype wire

// File: dv/ddi_data_source.sv
/*
 * data source model: buses, strobes, clocks, select.
 * assumes each task call starts just after a rising edge of clk_i.
 */
`default_nettype none

module ddi_data_source (
    input wire logic clk_i,
    output logic [13:0] bus_a_o,
    output logic [13:0] bus_b_o,
    output logic write_o,
    output logic clock_o,
    output logic select_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_a_o = 14'h0000;
        bus_b_o = 14'h3fff;
        write_o = 1'b0;
        clock_o = 1'b0;
        select_o = 1'b0;
    end

    // ----------------------------------------
    // one write and clock pulse
    // ----------------------------------------
    // write and clock rise together: equal periods
    task automatic strobe(input logic [13:0] wa, input logic [13:0] wb, input logic sel);
        bus_a_o <= wa;
        bus_b_o <= wb;
        select_o <= sel;
        write_o <= 1'b1;
        clock_o <= 1'b1;
        @(posedge clk_i);
        write_o <= 1'b0;
        clock_o <= 1'b0;
        // hold over: bus shows garbage, not the last word
        bus_a_o <= ~wa;
        bus_b_o <= ~wb;
        @(posedge clk_i);
    endtask : strobe
endmodule : ddi_data_source

`default_nettype wire

// File: dv/ddi_top_tb_top.sv
/*
 * bench of ddi_top: bus master, source model, scenarios.
 * assumes the checker binds itself.
 */
`default_nettype none

module ddi_top_tb_top
    import ddi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bus_mode_strap_i = 1'b1;
    logic gain_set_strap_i = 1'b1;
    logic pair_align_reset_i = 1'b0;
    logic sample_ready_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, wr, ck, sel, div_clk, bias, s_valid;
    logic [13:0] bus_a, bus_b, prim_a, comp_a, prim_b, comp_b, s_code_a, hold_b;
    logic [13:0] exp_a [64], exp_b [64];
    int n, checks, mismatches, cycles;
    bit chk_b = 1'b1;

    always #20 clk_i = ~clk_i;

    ddi_data_source src (.clk_i(clk_i), .bus_a_o(bus_a), .bus_b_o(bus_b),
        .write_o(wr), .clock_o(ck), .select_o(sel));

    ddi_top DUT (.clk_i(clk_i), .rst_i(rst_i), .bus_mode_strap_i(bus_mode_strap_i),
        .gain_set_strap_i(gain_set_strap_i), .bus_a_i(bus_a), .bus_b_i(bus_b),
        .write_strobe_a_i(wr), .write_strobe_b_i(wr), .dac_clock_a_i(ck), .dac_clock_b_i(ck),
        .channel_select_i(sel), .pair_align_reset_i(pair_align_reset_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .primary_current_a_o(prim_a), .complementary_current_a_o(comp_a),
        .primary_current_b_o(prim_b), .complementary_current_b_o(comp_b),
        .segment_switch_a_o(), .segment_switch_b_o(), .divided_dac_latch_clock_o(div_clk),
        .bias_b_from_resistor_a_o(bias), .sample_valid_o(s_valid),
        .sample_ready_i(sample_ready_i), .sample_code_a_o(s_code_a), .sample_code_b_o(),
        .sample_tag_o());

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // run needs under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] wd);
        wb_adr_i <= adr;
        wb_we_i <= we;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_xfer

    task automatic reset_dut;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        n = 0;
    endtask : reset_dut

    function automatic logic [13:0] wordf(input int k);
        return (k == 0) ? 14'h3fff : (k == 1) ? 14'h0000 : 14'(k * 32'h0000_0a5b);
    endfunction : wordf

    // one word per channel; the word sent four updates earlier must show
    task automatic send(input logic [13:0] a, input logic [13:0] b);
        exp_a[n] = a;
        exp_b[n] = b;
        if (bus_mode_strap_i) begin
            src.strobe(a, b, 1'b1);
        end else begin
            src.strobe(a, ~a, 1'b1);
            src.strobe(b, ~b, 1'b0);
        end
        @(negedge clk_i);
        if (n >= 4) begin
            check(32'(prim_a), 32'(exp_a[n-4]));
            if (chk_b) check(32'(prim_b), 32'(exp_b[n-4]));
        end
        n++;
        @(posedge clk_i);
    endtask : send

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_regs;
        wb_xfer(DDI_CTRL_OFS, 1'b0, 32'h0000_0000);
        check(rd, 32'(DDI_CTRL_RST));
        wb_xfer(8'h40, 1'b1, 32'h0000_0000);
        wb_xfer(8'h40, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        wb_xfer(DDI_STATUS_OFS, 1'b0, 32'h0000_0000);
        check(rd & 32'h0000_000b, 32'h0000_0003);
    endtask : sc_regs

    task automatic sc_dual;
        for (int k = 0; k < 10; k++) send(wordf(k), wordf(k + 5));
        wb_xfer(DDI_CODE_A_OFS, 1'b0, 32'h0000_0000);
        check(rd, 32'(exp_a[n-5]));
        check(32'(bias), 32'h0000_0001);
    endtask : sc_dual

    task automatic sc_disable_b;
        wb_xfer(DDI_CTRL_OFS, 1'b1, 32'h0000_0001);
        hold_b = prim_b;
        chk_b = 1'b0;
        for (int k = 0; k < 5; k++) send(wordf(k + 2), wordf(k + 7));
        check(32'(prim_b), 32'(hold_b));
        chk_b = 1'b1;
        wb_xfer(DDI_CTRL_OFS, 1'b1, 32'h0000_0003);
    endtask : sc_disable_b

    // stalled consumer: two kept, third refused and flagged
    task automatic sc_stall;
        sample_ready_i <= 1'b0;
        for (int k = 0; k < 3; k++) src.strobe(wordf(k), wordf(k), 1'b1);
        @(negedge clk_i);
        check(32'(s_valid), 32'h0000_0001);
        check(32'(s_code_a), 32'(exp_a[n-4]));
        @(posedge clk_i);
        wb_xfer(DDI_STATUS_OFS, 1'b0, 32'h0000_0000);
        check(rd & 32'h0000_0008, 32'h0000_0008);
        sample_ready_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check(32'(s_valid), 32'h0000_0000);
        wb_xfer(DDI_STATUS_OFS, 1'b1, 32'h0000_0008);
        wb_xfer(DDI_STATUS_OFS, 1'b0, 32'h0000_0000);
        check(rd & 32'h0000_0008, 32'h0000_0000);
    endtask : sc_stall

    task automatic sc_interleave;
        bus_mode_strap_i <= 1'b0;
        gain_set_strap_i <= 1'b0;
        reset_dut();
        pair_align_reset_i <= 1'b1;
        repeat (3) src.strobe(14'h1555, 14'h2aaa, 1'b1);
        @(negedge clk_i);
        check(32'(div_clk), 32'h0000_0000);
        @(posedge clk_i);
        pair_align_reset_i <= 1'b0;
        wb_xfer(DDI_STATUS_OFS, 1'b0, 32'h0000_0000);
        check(rd & 32'h0000_0003, 32'h0000_0000);
        check(32'(bias), 32'h0000_0000);
        for (int k = 0; k < 10; k++) send(wordf(k), wordf(k + 3));
    endtask : sc_interleave

    initial begin
        reset_dut();
        sc_regs();
        sc_dual();
        sc_disable_b();
        sc_stall();
        sc_interleave();
        final_report();
    end
endmodule : ddi_top_tb_top

`default_nettype wire
